// File: shared/efp_pkg.sv
// Package with constants, types and the behaviour summary of the earth-fault stages
// Operation
// - Differential trip asserts at once when differential current exceeds its start level.
// - Differential operate time is fixed, well inside the nominal 35 ms.
// - Neutral current above its level raises start output and yellow indicator.
// - Neutral trip asserts once operate time elapses with start still present.
// - A tripping stage drives its own indicator red.
// - Indicator config chooses self-reset or held start and trip indications.
// - Held indications clear on reset button or either remote clear command.
// - Active differential block prevents the differential stage from tripping.
// - Active neutral block prevents the neutral stage from tripping.
// - Routing group bits route external block inputs to the stages.
// - Routing group bits select which stage signals drive reclose starts.
// - Differential start level settable over 0,5...5% of rated current.
// - Neutral start level settable over 5...40% of rated current.
// - One selector switch chooses definite or inverse neutral characteristic.
// - Definite mode offers spans 0.1...1 s, 1...10 s, 10...100 s.
// - Two selector switches choose the active definite-time span.
// - In inverse mode the same two switches choose one of four curves.
// - With latching on, a trip stays asserted after current falls back.
// - Latched trip clears on step plus reset together, or either remote clear.
// - Differential and neutral trip latching each have their own switch.
// - Internal fault raises the alarm and blocks trip, start and reclose outputs; held indications stay lit.
// - Differential indicator shows red on trip only, no start indication.
// - Without latching, trip drops as soon as current falls below level.
package efp_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_SELECT = 8'h00;
  localparam logic [7:0] REG_DIFF_LEVEL = 8'h04;
  localparam logic [7:0] REG_NEUT_LEVEL = 8'h08;
  localparam logic [7:0] REG_NEUT_TIME = 8'h0C;
  localparam logic [7:0] REG_COMMAND = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  // Front selector bits, bit n-1 is switch n
  localparam int SEL_DIFF_LATCH = 2;
  localparam int SEL_NEUT_LATCH = 3;
  localparam int SEL_INVERSE = 5;
  localparam int SEL_RANGE_LO = 6;
  // Indicator config bits, set means held
  localparam int IND_NEUT_START_HELD = 0;
  localparam int IND_NEUT_TRIP_HELD = 1;
  localparam int IND_DIFF_TRIP_HELD = 2;
  // Routing bits: [2:0] to diff block, [5:3] to neutral block
  localparam int ROUTE_DIFF_LO = 0;
  localparam int ROUTE_NEUT_LO = 3;
  localparam int ROUTE_A_FROM_TRIP = 6;
  localparam int ROUTE_B_FROM_NEUT = 7;
  // Command bits
  localparam int CMD_CLEAR_ALL = 0;
  localparam int CMD_CLEAR_IND = 1;
  // Level codes in tenths of a percent of rated current
  localparam logic [15:0] DIFF_LEVEL_MIN = 16'h0005;
  localparam logic [15:0] DIFF_LEVEL_MAX = 16'h0032;
  localparam logic [15:0] NEUT_LEVEL_MIN = 16'h0032;
  localparam logic [15:0] NEUT_LEVEL_MAX = 16'h0190;
  // Reset values
  localparam logic [23:0] SELECT_RESET = 24'h000000;
  localparam logic [15:0] DIFF_LEVEL_RESET = 16'h0005;
  localparam logic [15:0] NEUT_LEVEL_RESET = 16'h0032;
  localparam logic [3:0] MULT_RESET = 4'h1;
  // Timing
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int DIFF_OPERATE_MS = 35;
  localparam int RANGE0_BASE_MS = 100;
  localparam logic [11:0] RANGE0_TICKS = 12'(RANGE0_BASE_MS / TICK_MS);
  localparam logic [11:0] RANGE1_TICKS = 12'(RANGE0_BASE_MS * 10 / TICK_MS);
  localparam logic [11:0] RANGE2_TICKS = 12'(RANGE0_BASE_MS * 100 / TICK_MS);
  localparam logic [3:0] MULT_MIN = 4'h1;
  localparam logic [3:0] MULT_MAX = 4'hA;
  // Inverse curve constants, ticks per unit of excess current per level
  localparam logic [7:0] CURVE0 = 8'h0E;
  localparam logic [7:0] CURVE1 = 8'h1B;
  localparam logic [7:0] CURVE2 = 8'h50;
  localparam logic [7:0] CURVE3 = 8'hC8;

  typedef struct packed {
    logic [7:0] route;
    logic [7:0] ind;
    logic [7:0] front;
  } efp_select_t;

  typedef struct packed {
    logic alarm;
    logic neutRed;
    logic neutYellow;
    logic diffRed;
    logic recloseB;
    logic recloseA;
    logic neutStart;
    logic neutTrip;
    logic diffTrip;
  } efp_status_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ANSWER = 3'b010,
    BUS_DONE = 3'b100
  } efp_bus_t;
endpackage

// File: verilog/efp_op_timer.sv
// Neutral stage operate timer, definite or inverse characteristic
`timescale 1ns/1ps
module efp_op_timer
  import efp_pkg::*;
#(
  parameter int ACC_W = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic tick,
  input wire logic inverse,
  input wire logic [1:0] rangeSel,
  input wire logic [3:0] mult,
  input wire logic [15:0] excess,
  input wire logic [15:0] level,
  output logic expired
);
  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] limit;
  logic [3:0] multUse;
  logic [11:0] rangeTicks;
  logic [7:0] curve;

  always_comb begin
    multUse = (mult < MULT_MIN) ? MULT_MIN : ((mult > MULT_MAX) ? MULT_MAX : mult);
    unique case (rangeSel)
      2'b00: rangeTicks = RANGE0_TICKS;
      2'b01: rangeTicks = RANGE1_TICKS;
      default: rangeTicks = RANGE2_TICKS;
    endcase
    unique case (rangeSel)
      2'b00: curve = CURVE0;
      2'b01: curve = CURVE1;
      2'b10: curve = CURVE2;
      default: curve = CURVE3;
    endcase
    if (inverse) begin
      limit = ACC_W'(multUse * curve * level);
    end else begin
      limit = ACC_W'(multUse * rangeTicks);
    end
  end

  // Definite mode counts ticks; inverse mode integrates excess current
  always_ff @(posedge ref_clk) begin
    if (rst || !run) begin
      acc <= '0;
    end else if (tick && !expired) begin
      acc <= inverse ? ACC_W'(acc + excess) : ACC_W'(acc + 1'b1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !run) begin
      expired <= 1'b0;
    end else begin
      expired <= (acc >= limit);
    end
  end
endmodule

// File: verilog/efp_stages.sv
// Earth-fault differential and neutral protection stages with register slave
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
module efp_stages
  import efp_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [15:0] diffCurrent,
  input wire logic [15:0] neutralCurrent,
  input wire logic [2:0] blockIn,
  input wire logic resetButton,
  input wire logic stepButton,
  input wire logic internalFault,
  output logic diff_trip_out,
  output logic neutral_trip_out,
  output logic neutral_start_out,
  output logic reclose_start_a,
  output logic reclose_start_b,
  output logic alarmOut,
  output logic diffIndRed,
  output logic neutIndYellow,
  output logic neutIndRed
);
  efp_select_t selectReg;
  logic [15:0] diffLevel;
  logic [15:0] neutLevel;
  logic [3:0] neutMult;
  efp_bus_t busState;
  logic writeTake;
  logic remote_clear_all_cmd;
  logic remote_clear_ind_cmd;
  logic [19:0] tickCount;
  logic tick;
  logic diffOver;
  logic neutOver;
  logic diffBlock;
  logic neutBlock;
  logic diffLatch;
  logic neutLatch;
  logic diffTripRaw;
  logic neutTripRaw;
  logic timerExpired;
  logic faultHeld;
  logic clearLatch;
  logic clearInd;
  logic diffRedHeld;
  logic neutRedHeld;
  logic neutYellowHeld;
  logic [15:0] neutExcess;
  efp_status_t status;

  // Register slave: one wait cycle, then answer for one cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busState <= BUS_IDLE;
    end else begin
      unique case (busState)
        BUS_IDLE: begin
          if (read || write) begin
            busState <= BUS_ANSWER;
          end
        end
        BUS_ANSWER: busState <= BUS_DONE;
        BUS_DONE: busState <= BUS_IDLE;
        default: busState <= BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !(busState == BUS_IDLE && (read || write));
    end
  end

  assign writeTake = write && (busState == BUS_ANSWER);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      readdata <= '0;
    end else if (busState == BUS_IDLE && read) begin
      unique case (address)
        REG_SELECT: readdata <= {8'h00, selectReg};
        REG_DIFF_LEVEL: readdata <= {16'h0000, diffLevel};
        REG_NEUT_LEVEL: readdata <= {16'h0000, neutLevel};
        REG_NEUT_TIME: readdata <= {28'h0000000, neutMult};
        REG_STATUS: readdata <= {23'h000000, status};
        default: readdata <= '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      selectReg <= SELECT_RESET;
    end else if (writeTake && address == REG_SELECT) begin
      selectReg <= writedata[23:0];
    end
  end

  // Levels are clamped to their settable spans
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      diffLevel <= DIFF_LEVEL_RESET;
    end else if (writeTake && address == REG_DIFF_LEVEL) begin
      if (writedata[15:0] < DIFF_LEVEL_MIN) begin
        diffLevel <= DIFF_LEVEL_MIN;
      end else if (writedata[15:0] > DIFF_LEVEL_MAX) begin
        diffLevel <= DIFF_LEVEL_MAX;
      end else begin
        diffLevel <= writedata[15:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      neutLevel <= NEUT_LEVEL_RESET;
    end else if (writeTake && address == REG_NEUT_LEVEL) begin
      if (writedata[15:0] < NEUT_LEVEL_MIN) begin
        neutLevel <= NEUT_LEVEL_MIN;
      end else if (writedata[15:0] > NEUT_LEVEL_MAX) begin
        neutLevel <= NEUT_LEVEL_MAX;
      end else begin
        neutLevel <= writedata[15:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      neutMult <= MULT_RESET;
    end else if (writeTake && address == REG_NEUT_TIME) begin
      neutMult <= writedata[3:0];
    end
  end

  // Remote clear commands are one-cycle pulses
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      remote_clear_all_cmd <= 1'b0;
      remote_clear_ind_cmd <= 1'b0;
    end else begin
      remote_clear_all_cmd <= writeTake && address == REG_COMMAND && writedata[CMD_CLEAR_ALL];
      remote_clear_ind_cmd <= writeTake && address == REG_COMMAND && writedata[CMD_CLEAR_IND];
    end
  end

  assign clearLatch = (stepButton && resetButton) || remote_clear_all_cmd || remote_clear_ind_cmd;
  assign clearInd = resetButton || remote_clear_all_cmd || remote_clear_ind_cmd;

  // Time base for the operate timer
  always_ff @(posedge ref_clk) begin
    if (rst || tickCount == 20'(TICK_LEN - 1)) begin
      tickCount <= '0;
    end else begin
      tickCount <= tickCount + 20'h00001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= (tickCount == 20'(TICK_LEN - 1));
    end
  end

  // Level comparisons and block routing
  assign diffOver = diffCurrent > diffLevel;
  assign neutOver = neutralCurrent > neutLevel;
  assign neutExcess = neutOver ? 16'(neutralCurrent - neutLevel) : 16'h0000;
  assign diffBlock = |(blockIn & selectReg.route[ROUTE_DIFF_LO +: 3]);
  assign neutBlock = |(blockIn & selectReg.route[ROUTE_NEUT_LO +: 3]);

  efp_op_timer #(
    .ACC_W(32)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(neutOver),
    .tick(tick),
    .inverse(selectReg.front[SEL_INVERSE]),
    .rangeSel(selectReg.front[SEL_RANGE_LO +: 2]),
    .mult(neutMult),
    .excess(neutExcess),
    .level(neutLevel),
    .expired(timerExpired)
  );

  // Trip conditions before latching; blocks suppress them outright
  assign diffTripRaw = diffOver && !diffBlock;
  assign neutTripRaw = neutOver && timerExpired && !neutBlock;

  // Trip latches: a new trip wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      diffLatch <= 1'b0;
    end else begin
      diffLatch <= selectReg.front[SEL_DIFF_LATCH] && (diffTripRaw || (diffLatch && !clearLatch));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      neutLatch <= 1'b0;
    end else begin
      neutLatch <= selectReg.front[SEL_NEUT_LATCH] && (neutTripRaw || (neutLatch && !clearLatch));
    end
  end

  // Permanent fault is held until reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      faultHeld <= 1'b0;
    end else begin
      faultHeld <= faultHeld || internalFault;
    end
  end

  // Relay outputs, all dropped while the self-supervision alarm stands
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      diff_trip_out <= 1'b0;
      neutral_trip_out <= 1'b0;
      neutral_start_out <= 1'b0;
    end else begin
      diff_trip_out <= !faultHeld && !internalFault && !diffBlock && (diffTripRaw || diffLatch);
      neutral_trip_out <= !faultHeld && !internalFault && !neutBlock && (neutTripRaw || neutLatch);
      neutral_start_out <= !faultHeld && !internalFault && neutOver;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reclose_start_a <= 1'b0;
      reclose_start_b <= 1'b0;
    end else begin
      reclose_start_a <= !faultHeld && !internalFault &&
        (selectReg.route[ROUTE_A_FROM_TRIP] ? (neutTripRaw || neutLatch) : neutOver);
      reclose_start_b <= !faultHeld && !internalFault &&
        (selectReg.route[ROUTE_B_FROM_NEUT] ? (neutTripRaw || neutLatch) : (diffTripRaw || diffLatch));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alarmOut <= 1'b0;
    end else begin
      alarmOut <= faultHeld || internalFault;
    end
  end

  // Held indications; setting wins over a clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      diffRedHeld <= 1'b0;
      neutRedHeld <= 1'b0;
      neutYellowHeld <= 1'b0;
    end else begin
      diffRedHeld <= selectReg.ind[IND_DIFF_TRIP_HELD] && (diff_trip_out || (diffRedHeld && !clearInd));
      neutRedHeld <= selectReg.ind[IND_NEUT_TRIP_HELD] && (neutral_trip_out || (neutRedHeld && !clearInd));
      neutYellowHeld <= selectReg.ind[IND_NEUT_START_HELD] &&
        (neutral_start_out || (neutYellowHeld && !clearInd));
    end
  end

  // Indicators: red overrides yellow on the neutral stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      diffIndRed <= 1'b0;
      neutIndRed <= 1'b0;
      neutIndYellow <= 1'b0;
    end else begin
      diffIndRed <= diff_trip_out || diffRedHeld;
      neutIndRed <= neutral_trip_out || neutRedHeld;
      neutIndYellow <= !(neutral_trip_out || neutRedHeld) && (neutral_start_out || neutYellowHeld);
    end
  end

  always_comb begin
    status.alarm = alarmOut;
    status.neutRed = neutIndRed;
    status.neutYellow = neutIndYellow;
    status.diffRed = diffIndRed;
    status.recloseB = reclose_start_b;
    status.recloseA = reclose_start_a;
    status.neutStart = neutral_start_out;
    status.neutTrip = neutral_trip_out;
    status.diffTrip = diff_trip_out;
  end
endmodule

// File: testbench/efp_stages_properties.sv
// Port checker for the earth-fault stages
`timescale 1ns/1ps
module efp_stages_properties
  import efp_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic internalFault,
  input wire logic diff_trip_out,
  input wire logic neutral_trip_out,
  input wire logic neutral_start_out,
  input wire logic alarmOut,
  input wire logic diffIndRed,
  input wire logic neutIndYellow,
  input wire logic neutIndRed
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence reqRise;
    $rose(read || write);
  endsequence
  sequence faultSeen;
    internalFault ##2 1'b1;
  endsequence
  AST_BUS_ANSWER: assert property (reqRise |-> ##1 !waitrequest)
    else $error("bus answer not one cycle after request");
  AST_WAIT_ONE: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_FAULT_BLOCK: assert property (faultSeen |-> alarmOut && !diff_trip_out && !neutral_trip_out && !neutral_start_out)
    else $error("internal fault left outputs active");
  AST_ALARM_HOLD: assert property (alarmOut |=> alarmOut)
    else $error("alarm dropped without reset");
  AST_DIFF_RED: assert property ($rose(diffIndRed) |-> $past(diff_trip_out))
    else $error("differential red without trip");
  AST_NEUT_YELLOW: assert property ($rose(neutIndYellow) |-> $past(neutral_start_out))
    else $error("neutral yellow without start");
  AST_NEUT_RED: assert property ($rose(neutIndRed) |-> $past(neutral_trip_out))
    else $error("neutral red without trip");
  AST_TRIP_AFTER_START: assert property ($rose(neutral_trip_out) |-> $past(neutral_start_out))
    else $error("neutral trip without start");
endmodule

bind efp_stages efp_stages_properties #(.TICK_LEN(TICK_LEN)) chk (
  .ref_clk(ref_clk),
  .rst(rst),
  .read(read),
  .write(write),
  .waitrequest(waitrequest),
  .internalFault(internalFault),
  .diff_trip_out(diff_trip_out),
  .neutral_trip_out(neutral_trip_out),
  .neutral_start_out(neutral_start_out),
  .alarmOut(alarmOut),
  .diffIndRed(diffIndRed),
  .neutIndYellow(neutIndYellow),
  .neutIndRed(neutIndRed)
);

// File: testbench/efp_plant.sv
// Front-end model: current samples refreshed after a lag, block inputs
`timescale 1ns/1ps
module efp_plant
  import efp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [15:0] diffSet,
  input wire logic [15:0] neutSet,
  input wire logic [2:0] blockSet,
  input wire logic [3:0] lag,
  output logic [15:0] diffCurrent,
  output logic [15:0] neutralCurrent,
  output logic [2:0] blockIn
);
  logic [3:0] age;
  initial begin
    diffCurrent = 16'h0000;
    neutralCurrent = 16'h0000;
    blockIn = 3'h0;
    age = 4'h0;
  end
  always @(posedge ref_clk) begin
    blockIn <= blockSet;
    if (age < lag) begin
      age <= age + 4'h1;
    end else begin
      age <= 4'h0;
      diffCurrent <= diffSet;
      neutralCurrent <= neutSet;
    end
  end
endmodule

// File: testbench/efp_stages_test.sv
// Self-checking bench for the earth-fault stages
`timescale 1ns/1ps
module efp_stages_test
  import efp_pkg::*;
;
  typedef struct {string name; logic [31:0] v;} efp_note_t;
  efp_note_t notes[$];
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata, got, rdData;
  logic waitrequest;
  logic [15:0] diffSet = 16'h0000;
  logic [15:0] neutSet = 16'h0000;
  logic [15:0] diffCurrent, neutralCurrent;
  logic [2:0] blockSet = 3'h0;
  logic [2:0] blockIn;
  logic [3:0] lag = 4'h0;
  logic resetButton = 1'b0;
  logic stepButton = 1'b0;
  logic internalFault = 1'b0;
  efp_status_t outs;
  int bad_count = 0;
  int checked = 0;
  event resEv;
  logic [31:0] tSel [8] = '{32'h400000, 32'h400040, 32'h400080, 32'h4000C0,
    32'h400020, 32'h400060, 32'h4000A0, 32'h4000E0};
  int tLo [8] = '{32, 392, 3992, 3992, 20, 46, 152, 392};
  int tHi [8] = '{50, 410, 4010, 4010, 68, 120, 332, 812};

  efp_stages #(.TICK_LEN(4)) DUT (.ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .diffCurrent(diffCurrent), .neutralCurrent(neutralCurrent), .blockIn(blockIn),
    .resetButton(resetButton), .stepButton(stepButton), .internalFault(internalFault),
    .diff_trip_out(outs.diffTrip), .neutral_trip_out(outs.neutTrip), .neutral_start_out(outs.neutStart),
    .reclose_start_a(outs.recloseA), .reclose_start_b(outs.recloseB), .alarmOut(outs.alarm),
    .diffIndRed(outs.diffRed), .neutIndYellow(outs.neutYellow), .neutIndRed(outs.neutRed));
  efp_plant plant (.ref_clk(ref_clk), .diffSet(diffSet), .neutSet(neutSet), .blockSet(blockSet),
    .lag(lag), .diffCurrent(diffCurrent), .neutralCurrent(neutralCurrent), .blockIn(blockIn));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Holds the request until waitrequest is sampled low; only the watchdog ends a hang
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    rdData = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic note(string n, logic [31:0] v);
    efp_note_t e;
    e.name = n;
    e.v = v;
    notes.push_back(e);
  endtask

  task automatic rd(string n, logic [7:0] a, logic [31:0] e);
    note(n, e);
    bus(1'b0, a, 32'h00000000);
    got = rdData;
    ->resEv;
  endtask

  // Compare the output word under a mask
  task automatic chk(string n, logic [31:0] m, logic [31:0] e);
    note(n, e);
    got = {23'h000000, outs} & m;
    ->resEv;
  endtask

  initial begin
    efp_note_t e;
    forever begin
      @resEv;
      checked++;
      e = notes.pop_front();
      if (got !== e.v) begin
        bad_count++;
        $display("MISMATCH %s expected %h seen %h", e.name, e.v, got);
      end
    end
  end

  initial begin
    step(30000);
    bad_count++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h14A18072));
    step(8);
    rst <= 1'b0;
    rd("select", REG_SELECT, 32'(SELECT_RESET));
    rd("diff level", REG_DIFF_LEVEL, 32'(DIFF_LEVEL_RESET));
    rd("neutral level", REG_NEUT_LEVEL, 32'(NEUT_LEVEL_RESET));
    rd("multiplier", REG_NEUT_TIME, 32'(MULT_RESET));
    rd("unmapped", 8'h20, 32'h00000000);
    rd("command", REG_COMMAND, 32'h00000000);
    bus(1'b1, REG_DIFF_LEVEL, 32'(DIFF_LEVEL_MAX));
    rd("diff level", REG_DIFF_LEVEL, 32'(DIFF_LEVEL_MAX));
    lag <= 4'($urandom % 4);
    diffSet <= DIFF_LEVEL_MAX;
    step(8);
    chk("at level", 32'h1FF, 32'h0);
    diffSet <= DIFF_LEVEL_MAX + 16'h0001 + 16'($urandom % 100);
    step(8);
    chk("diff trip", 32'h1FF, 32'h31);
    rd("status", REG_STATUS, 32'h31);
    diffSet <= 16'h0000;
    step(8);
    chk("diff drop", 32'h1FF, 32'h0);
    bus(1'b1, REG_SELECT, 32'h010000);
    blockSet <= 3'h1;
    diffSet <= DIFF_LEVEL_MAX + 16'h0001 + 16'($urandom % 100);
    step(8);
    chk("blocked", 32'h1FF, 32'h0);
    blockSet <= 3'h2;
    step(8);
    chk("unrouted block", 32'h1FF, 32'h31);
    blockSet <= 3'h0;
    bus(1'b1, REG_SELECT, 32'h000004);
    diffSet <= 16'h0000;
    step(8);
    chk("latched", 32'h1FF, 32'h31);
    resetButton <= 1'b1;
    step(3);
    resetButton <= 1'b0;
    step(4);
    chk("reset alone", 32'h1FF, 32'h31);
    resetButton <= 1'b1;
    stepButton <= 1'b1;
    step(3);
    resetButton <= 1'b0;
    stepButton <= 1'b0;
    step(4);
    chk("buttons clear", 32'h1FF, 32'h0);
    for (int c = 0; c < 2; c++) begin
      diffSet <= DIFF_LEVEL_MAX + 16'h0001;
      step(8);
      diffSet <= 16'h0000;
      // Let the lagged current fall first, else the trip re-sets the latch over the clear
      step(4);
      bus(1'b1, REG_COMMAND, 32'h1 << c);
      step(4);
      chk("remote clear", 32'h1FF, 32'h0);
    end
    bus(1'b1, REG_SELECT, 32'h000400);
    diffSet <= DIFF_LEVEL_MAX + 16'h0001;
    step(8);
    diffSet <= 16'h0000;
    step(8);
    chk("held red", 32'h1FF, 32'h20);
    resetButton <= 1'b1;
    step(3);
    resetButton <= 1'b0;
    step(4);
    chk("red cleared", 32'h1FF, 32'h0);
    lag <= 4'h0;
    for (int t = 0; t < 8; t++) begin
      bus(1'b1, REG_SELECT, tSel[t]);
      neutSet <= 16'h0064;
      step(4);
      chk("start", 32'h0CF, 32'h044);
      step(tLo[t] - 4);
      chk("early", 32'h08F, 32'h004);
      step(tHi[t] - tLo[t]);
      chk("neutral trip", 32'h08F, 32'h08E);
      neutSet <= 16'h0000;
      step(6);
      chk("neutral drop", 32'h1FF, 32'h0);
    end
    bus(1'b1, REG_SELECT, 32'h400000);
    neutSet <= 16'h0064;
    step(25);
    neutSet <= 16'h0000;
    step(3);
    neutSet <= 16'h0064;
    step(25);
    chk("timer restart", 32'h08F, 32'h004);
    step(25);
    chk("trip after restart", 32'h08F, 32'h08E);
    neutSet <= 16'h0000;
    blockSet <= 3'h1;
    bus(1'b1, REG_SELECT, 32'h080000);
    neutSet <= 16'h0064;
    step(80);
    chk("neutral blocked", 32'h00E, 32'h00C);
    blockSet <= 3'h0;
    diffSet <= DIFF_LEVEL_MAX + 16'h0001;
    step(8);
    internalFault <= 1'b1;
    step(6);
    chk("fault", 32'h107, 32'h100);
    // Give the compare process time to take the last note
    step(2);
    end_of_test();
  end
endmodule
